//--- hw/ugp_edge_detect.sv
// pin synchroniser and polarity-selectable edge detector
module ugp_edge_detect
    import ugp_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    ugp_pin_if.det pins
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;
    logic [W-1:0] edge_q;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    // meta_q is read only by sync_q; pins are asynchronous to core_clk
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // idle level of a pulled-up line, so release makes no edge
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end else begin
            meta_q <= pins.pinRaw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

    // one pulse per qualifying edge, since prev_q follows sync_q
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_q <= '0;
        end else begin
            edge_q <= (pins.risingSel & rise)
                | (~pins.risingSel & fall);
        end
    end

    assign pins.level = sync_q;
    assign pins.edgeHit = edge_q;
endmodule

//--- hw/ugp_gpio_top.sv
// port pin logic with apb register access and pin interrupts
module ugp_gpio_top
    import ugp_pkg::*;
#(
    parameter int HIGH_W = HIGH_W_FULL,
    parameter int ADDR_W = 10
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LOW_W-1:0] lowPortIn,
    output logic [LOW_W-1:0] lowPortOut,
    output logic [LOW_W-1:0] lowPortOe_b,
    output logic [LOW_W-1:0] lowPortPullEn,
    output logic [LOW_W*SINK_W-1:0] lowPortSink,
    input wire logic [HIGH_W_FULL-1:0] highPortIn,
    output logic [HIGH_W_FULL-1:0] highPortOut,
    output logic [HIGH_W_FULL-1:0] highPortOe_b,
    output logic [HIGH_W_FULL-1:0] highPortPullEn,
    output logic [HIGH_W_FULL*SINK_W-1:0] highPortSink,
    input wire logic wakePinIn,
    output logic wakePinOut,
    output logic wakePinOe_b,
    output logic irq
);
    // full part has eight high-current lines, reduced part four
    if (HIGH_W != HIGH_W_FULL && HIGH_W != HIGH_W_REDUCED) begin : g_bad_w
        $error("HIGH_W must be 4 or 8");
    end
    if (ADDR_W < IDX_W + 2) begin : g_bad_a
        $error("ADDR_W too small for the register map");
    end

    // core_clk replaces the doubled resonator clock; edges are only
    // sampled faster, so no pin timing is lost
    localparam int CLK_RATIO = CORE_CLK_HZ / PORT_CLK_HZ;

    // lines that exist; absent high bits never change from reset
    localparam logic [HIGH_W_FULL-1:0] HIGH_MASK =
        HIGH_W_FULL'((1 << HIGH_W) - 1);

    function automatic logic hitIdx(input logic [IDX_W-1:0] idx,
                                    input logic [7:0] want);
        return idx == want;
    endfunction

    function automatic logic inRange(input logic [IDX_W-1:0] idx,
                                     input logic [7:0] base,
                                     input int n);
        return (idx >= base) && (idx < base + 8'(n));
    endfunction

    ugp_apb_state_type apbState_q;
    logic [IDX_W-1:0] idx;
    logic aligned;
    logic accessPh;
    logic wrStb;
    logic [7:0] wByte;
    logic lane0;
    logic mapped;
    logic [7:0] rdByte;

    logic [LOW_W-1:0] lowData_q;
    logic [HIGH_W_FULL-1:0] highData_q;
    logic [LOW_W-1:0] lowIe_q;
    logic [HIGH_W_FULL-1:0] highIe_q;
    logic [LOW_W-1:0] lowPol_q;
    logic [HIGH_W_FULL-1:0] highPol_q;
    logic [LOW_W-1:0] lowStat_q;
    logic [HIGH_W_FULL-1:0] highStat_q;
    logic wakeStat_q;
    logic wakeMask_q;
    logic wakeRelease_q;

    ugp_pin_if #(.W(LOW_W)) lowIf ();
    ugp_pin_if #(.W(HIGH_W_FULL)) highIf ();
    ugp_pin_if #(.W(1)) wakeIf ();

    assign lowIf.pinRaw = lowPortIn;
    assign lowIf.risingSel = lowPol_q;
    // absent lines sit at the idle level and never make an edge
    assign highIf.pinRaw = highPortIn | ~HIGH_MASK;
    assign highIf.risingSel = highPol_q;
    assign wakeIf.pinRaw = wakePinIn;
    assign wakeIf.risingSel = 1'b1;

    ugp_edge_detect #(.W(LOW_W)) u_low (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pins(lowIf)
    );

    ugp_edge_detect #(.W(HIGH_W_FULL)) u_high (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pins(highIf)
    );

    ugp_edge_detect #(.W(1)) u_wake (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pins(wakeIf)
    );

    // apb decode
    assign idx = paddr[IDX_W+1:2];
    assign aligned = paddr[1:0] == 2'b00 && (paddr >> (IDX_W + 2)) == '0;
    assign accessPh = psel && penable && apbState_q == APB_ANSWER;
    assign wrStb = accessPh && pwrite && aligned && lane0;
    assign wByte = pwdata[7:0];
    // a write with lane 0 switched off stores nothing
    assign lane0 = pstrb[0];

    always_comb begin
        mapped = hitIdx(idx, IDX_LOW_DATA) || hitIdx(idx, IDX_HIGH_DATA)
            || hitIdx(idx, IDX_LOW_IE) || hitIdx(idx, IDX_HIGH_IE)
            || hitIdx(idx, IDX_LOW_PULL) || hitIdx(idx, IDX_HIGH_PULL)
            || hitIdx(idx, IDX_WAKE_CTRL)
            || inRange(idx, IDX_LOW_SINK, LOW_W)
            || inRange(idx, IDX_HIGH_SINK, HIGH_W_FULL)
            || hitIdx(idx, IDX_LOW_POL) || hitIdx(idx, IDX_HIGH_POL)
            || hitIdx(idx, IDX_LOW_STAT) || hitIdx(idx, IDX_HIGH_STAT)
            || hitIdx(idx, IDX_WAKE_STAT) || hitIdx(idx, IDX_WAKE_MASK);
        mapped = mapped && aligned;
    end

    // write-only registers read back as zero
    always_comb begin
        rdByte = 8'h00;
        if (hitIdx(idx, IDX_LOW_DATA)) begin
            rdByte = lowIf.level;
        end else if (hitIdx(idx, IDX_HIGH_DATA)) begin
            rdByte = highIf.level & HIGH_MASK;
        end else if (hitIdx(idx, IDX_WAKE_CTRL)) begin
            rdByte[WAKE_RELEASE_BIT] = wakeRelease_q;
            rdByte[WAKE_LEVEL_BIT] = wakeIf.level[0];
        end else if (hitIdx(idx, IDX_LOW_POL)) begin
            rdByte = lowPol_q;
        end else if (hitIdx(idx, IDX_HIGH_POL)) begin
            rdByte = highPol_q;
        end else if (hitIdx(idx, IDX_LOW_STAT)) begin
            rdByte = lowStat_q;
        end else if (hitIdx(idx, IDX_HIGH_STAT)) begin
            rdByte = highStat_q;
        end else if (hitIdx(idx, IDX_WAKE_STAT)) begin
            rdByte[0] = wakeStat_q;
        end else if (hitIdx(idx, IDX_WAKE_MASK)) begin
            rdByte[0] = wakeMask_q;
        end
    end

    // one wait state: answer comes in the second access cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            apbState_q <= APB_IDLE;
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            unique case (apbState_q)
                APB_IDLE: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (psel && penable) begin
                        apbState_q <= APB_ANSWER;
                        pready <= 1'b1;
                        pslverr <= !mapped;
                        prdata <= (pwrite || !mapped) ? '0
                            : {{(DATA_W-8){1'b0}}, rdByte};
                    end
                end
                APB_ANSWER: begin
                    apbState_q <= APB_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // port data drive low where a zero is stored, released on a one
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowData_q <= DATA_RST;
            highData_q <= DATA_RST;
        end else if (wrStb) begin
            if (hitIdx(idx, IDX_LOW_DATA)) begin
                lowData_q <= wByte;
            end
            if (hitIdx(idx, IDX_HIGH_DATA)) begin
                highData_q <= (wByte & HIGH_MASK) | ~HIGH_MASK;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowIe_q <= IE_RST;
            highIe_q <= IE_RST;
            lowPol_q <= POL_RST;
            highPol_q <= POL_RST;
            wakeMask_q <= 1'b0;
        end else if (wrStb) begin
            if (hitIdx(idx, IDX_LOW_IE)) begin
                lowIe_q <= wByte;
            end
            if (hitIdx(idx, IDX_HIGH_IE)) begin
                highIe_q <= wByte & HIGH_MASK;
            end
            if (hitIdx(idx, IDX_LOW_POL)) begin
                lowPol_q <= wByte;
            end
            if (hitIdx(idx, IDX_HIGH_POL)) begin
                highPol_q <= wByte & HIGH_MASK;
            end
            if (hitIdx(idx, IDX_WAKE_MASK)) begin
                wakeMask_q <= wByte[0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowPortPullEn <= PULL_RST;
            highPortPullEn <= PULL_RST;
        end else if (wrStb) begin
            if (hitIdx(idx, IDX_LOW_PULL)) begin
                lowPortPullEn <= wByte;
            end
            if (hitIdx(idx, IDX_HIGH_PULL)) begin
                highPortPullEn <= wByte & HIGH_MASK;
            end
        end
    end

    // one sink register per pin; only the low nibble is kept
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowPortSink <= {LOW_W{SINK_RST}};
            highPortSink <= {HIGH_W_FULL{SINK_RST}};
        end else if (wrStb) begin
            for (int i = 0; i < LOW_W; i++) begin
                if (hitIdx(idx, IDX_LOW_SINK + 8'(i))) begin
                    lowPortSink[i*SINK_W +: SINK_W] <=
                        wByte[SINK_W-1:0];
                end
            end
            for (int i = 0; i < HIGH_W; i++) begin
                if (hitIdx(idx, IDX_HIGH_SINK + 8'(i))) begin
                    highPortSink[i*SINK_W +: SINK_W] <=
                        wByte[SINK_W-1:0];
                end
            end
        end
    end

    // pin drivers: open drain, enable low while pulling the line low
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowPortOut <= '0;
            lowPortOe_b <= '1;
            highPortOut <= '0;
            highPortOe_b <= '1;
        end else begin
            lowPortOut <= '0;
            lowPortOe_b <= lowData_q;
            highPortOut <= '0;
            highPortOe_b <= highData_q | ~HIGH_MASK;
        end
    end

    // wake pin: pulled low to discharge the rc, released to time out
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wakeRelease_q <= WAKE_RELEASE_RST;
            wakePinOut <= 1'b0;
            wakePinOe_b <= 1'b1;
        end else begin
            if (wrStb && hitIdx(idx, IDX_WAKE_CTRL)) begin
                wakeRelease_q <= wByte[WAKE_RELEASE_BIT];
            end
            wakePinOut <= 1'b0;
            wakePinOe_b <= wakeRelease_q;
        end
    end

    // sticky status, write one to clear; a new edge wins over the clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowStat_q <= '0;
            highStat_q <= '0;
            wakeStat_q <= 1'b0;
        end else begin
            lowStat_q <= (lowStat_q & ~((wrStb
                && hitIdx(idx, IDX_LOW_STAT)) ? wByte : 8'h00))
                | lowIf.edgeHit;
            highStat_q <= ((highStat_q & ~((wrStb
                && hitIdx(idx, IDX_HIGH_STAT)) ? wByte : 8'h00))
                | highIf.edgeHit) & HIGH_MASK;
            wakeStat_q <= (wakeStat_q & ~(wrStb
                && hitIdx(idx, IDX_WAKE_STAT) && wByte[0]))
                | wakeIf.edgeHit[0];
        end
    end

    // level interrupt; pin enables double as the status mask
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(lowStat_q & lowIe_q) || |(highStat_q & highIe_q)
                || (wakeStat_q && wakeMask_q);
        end
    end
endmodule

//--- include/ugp_pin_if.sv
// pin sampling and edge detection link between core and detector
interface ugp_pin_if #(parameter int W = 8);
    logic [W-1:0] pinRaw;
    logic [W-1:0] risingSel;
    logic [W-1:0] level;
    logic [W-1:0] edgeHit;
    modport core (output pinRaw, output risingSel, input level, input edgeHit);
    modport det (input pinRaw, input risingSel, output level, output edgeHit);
endinterface

//--- include/ugp_pkg.sv
// constants, types and register map of the usb mcu port pin block
package ugp_pkg;
    localparam int LOW_W = 8;
    localparam int HIGH_W_FULL = 8;
    localparam int HIGH_W_REDUCED = 4;
    localparam int SINK_W = 4;
    localparam int IDX_W = 8;
    localparam int DATA_W = 32;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_LOW_DATA = 8'h00;
    localparam logic [7:0] IDX_HIGH_DATA = 8'h01;
    localparam logic [7:0] IDX_LOW_IE = 8'h04;
    localparam logic [7:0] IDX_HIGH_IE = 8'h05;
    localparam logic [7:0] IDX_LOW_PULL = 8'h08;
    localparam logic [7:0] IDX_HIGH_PULL = 8'h09;
    localparam logic [7:0] IDX_WAKE_CTRL = 8'h22;
    localparam logic [7:0] IDX_LOW_SINK = 8'h30;
    localparam logic [7:0] IDX_HIGH_SINK = 8'h38;
    localparam logic [7:0] IDX_LOW_POL = 8'h40;
    localparam logic [7:0] IDX_HIGH_POL = 8'h41;
    localparam logic [7:0] IDX_LOW_STAT = 8'h42;
    localparam logic [7:0] IDX_HIGH_STAT = 8'h43;
    localparam logic [7:0] IDX_WAKE_STAT = 8'h44;
    localparam logic [7:0] IDX_WAKE_MASK = 8'h45;
    // wake control fields
    localparam int WAKE_RELEASE_BIT = 0;
    localparam int WAKE_LEVEL_BIT = 1;
    // reset values
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] IE_RST = 8'h00;
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [3:0] SINK_RST = 4'h0;
    localparam logic WAKE_RELEASE_RST = 1'b1;
    // clocking
    localparam int RESONATOR_HZ = 6_000_000;
    localparam int PORT_CLK_HZ = 2 * RESONATOR_HZ;
    localparam int CORE_CLK_HZ = 125_000_000;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_ANSWER = 1'b1
    } ugp_apb_state_type;
endpackage

//--- tb/ugp_gpio_bench.sv
// self-checking bench for the port pin block with a pin load model
module ugp_gpio_bench
    import ugp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HW = HIGH_W_REDUCED;
    localparam logic [7:0] HM = 8'h0f;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata, lowPortSink, highPortSink, rdV;
    logic pready, pslverr, irq, wakePinOut, wakePinOe_b, errV;
    logic [7:0] lowPortOut, lowPortOe_b, lowPortPullEn, highPortOut;
    logic [7:0] highPortOe_b, highPortPullEn, v, ie;
    logic [16:0] swEn = '1;
    logic [16:0] swVal = '1;
    logic [16:0] pinLevel;
    logic [7:0] dat [2];
    logic [3:0] snk [16];
    int errTotal = 0;
    int samplesChecked = 0;
    int cycles = 0;
    int seed = 61027;
    int j;
    int p;

    always #4 core_clk = ~core_clk;

    ugp_gpio_top #(.HIGH_W(HW)) ugp_gpio_top_inst (.core_clk(core_clk),
        .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lowPortIn(pinLevel[7:0]),
        .lowPortOut(lowPortOut), .lowPortOe_b(lowPortOe_b),
        .lowPortPullEn(lowPortPullEn), .lowPortSink(lowPortSink),
        .highPortIn(pinLevel[15:8]), .highPortOut(highPortOut),
        .highPortOe_b(highPortOe_b), .highPortPullEn(highPortPullEn),
        .highPortSink(highPortSink), .wakePinIn(pinLevel[16]),
        .wakePinOut(wakePinOut), .wakePinOe_b(wakePinOe_b), .irq(irq));
    ugp_pin_load #(.W(17)) ugp_pin_load_inst (.core_clk(core_clk),
        .pinOe_b({wakePinOe_b, highPortOe_b, lowPortOe_b}),
        .pullEn({1'b0, highPortPullEn, lowPortPullEn}), .swEn(swEn),
        .swVal(swVal), .pinLevel(pinLevel));

    task automatic finalReport;
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
            input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
            input logic [7:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdV = prdata;
        errV = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
            input string name);
        apb(1'b0, idx, 8'h00);
        chk(name, {24'h0, exp}, rdV);
        chk("slverr", 32'h0, {31'h0, errV});
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            finalReport();
        end
    end

    initial begin
        repeat (5) @(posedge core_clk);
        chk("oe", 32'h1ffff,
            {15'h0, wakePinOe_b, highPortOe_b, lowPortOe_b});
        chk("pull", 32'h0, {16'h0, lowPortPullEn, highPortPullEn});
        chk("sink", 32'h0, lowPortSink | highPortSink);
        chk("irq", 32'h0, {31'h0, irq});
        rst_b <= 1'b1;
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            v = 8'($random(seed));
            dat[0] = 8'($random(seed));
            dat[1] = 8'($random(seed));
            swVal[15:0] <= {v, ~v};
            apb(1'b1, IDX_LOW_DATA, dat[0]);
            apb(1'b1, IDX_HIGH_DATA, dat[1]);
            repeat (4) @(posedge core_clk);
            chk("lowOe", {24'h0, dat[0]}, {24'h0, lowPortOe_b});
            chk("highOe", {24'h0, dat[1] | ~HM},
                {24'h0, highPortOe_b});
            rd(IDX_LOW_DATA, dat[0] & ~v, "lowPin");
            rd(IDX_HIGH_DATA, dat[1] & v & HM, "highPin");
        end
        apb(1'b1, IDX_LOW_DATA, 8'hff);
        apb(1'b1, IDX_HIGH_DATA, 8'hff);
        swVal <= '1;
        $display("data test done");
        v = 8'($random(seed));
        apb(1'b1, IDX_LOW_PULL, v);
        apb(1'b1, IDX_HIGH_PULL, ~v);
        // lane 0 strobe off: this write must leave the pull-ups alone
        pstrb <= 4'he;
        apb(1'b1, IDX_LOW_PULL, ~v);
        pstrb <= 4'hf;
        swEn[7:0] <= 8'h00;
        repeat (4) @(posedge core_clk);
        chk("pullEn", {16'h0, v, ~v & HM},
            {16'h0, lowPortPullEn, highPortPullEn});
        rd(IDX_LOW_PULL, 8'h00, "pullRd");
        apb(1'b0, IDX_LOW_DATA, 8'h00);
        chk("pullPin", {24'h0, v}, rdV & {24'h0, v});
        swEn <= '1;
        for (int i = 0; i < 16; i++) begin
            snk[i] = 4'($random(seed));
            apb(1'b1, 8'(IDX_LOW_SINK + i), {4'h0, snk[i]});
        end
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 16; i++) begin
            chk("sinkLvl", (i < 8 + HW) ? 32'(snk[i]) : 32'h0,
                i < 8 ? 32'(lowPortSink[4*i+:4])
                : 32'(highPortSink[4*(i-8)+:4]));
        end
        rd(IDX_HIGH_SINK, 8'h00, "sinkRd");
        $display("control test done");
        // first half low-current port, second half high-current port
        for (int m = 0; m < 8; m++) begin
            p = m / 4;
            j = {$random(seed)} % (p ? HW : 8);
            ie = m[1] ? 8'h1 << j : 8'h00;
            swVal[j + 8 * p] <= ~m[0];
            apb(1'b1, IDX_LOW_POL + 8'(p), m[0] ? 8'hff : 8'h00);
            apb(1'b1, IDX_LOW_IE + 8'(p), ie);
            repeat (6) @(posedge core_clk);
            apb(1'b1, IDX_LOW_STAT + 8'(p), 8'hff);
            swVal[j + 8 * p] <= m[0];
            repeat (8) @(posedge core_clk);
            rd(IDX_LOW_STAT + 8'(p), 8'h1 << j, "stat");
            chk("irqOn", {31'h0, m[1]}, {31'h0, irq});
            apb(1'b1, IDX_LOW_STAT + 8'(p), 8'h1 << j);
            swVal[j + 8 * p] <= ~m[0];
            repeat (8) @(posedge core_clk);
            rd(IDX_LOW_STAT + 8'(p), 8'h00, "statOff");
            chk("irqOff", 32'h0, {31'h0, irq});
        end
        $display("pin interrupt test done");
        apb(1'b1, IDX_WAKE_MASK, 8'h01);
        apb(1'b1, IDX_WAKE_CTRL, 8'h00);
        repeat (4) @(posedge core_clk);
        chk("wakeOe", 32'h0, {31'h0, wakePinOe_b});
        rd(IDX_WAKE_CTRL, 8'h00, "wakeLow");
        apb(1'b1, IDX_WAKE_STAT, 8'h01);
        apb(1'b1, IDX_WAKE_CTRL, 8'h01);
        repeat (8) @(posedge core_clk);
        rd(IDX_WAKE_STAT, 8'h01, "wakeRise");
        chk("wakeIrq", 32'h1, {31'h0, irq});
        apb(1'b1, IDX_WAKE_STAT, 8'h01);
        swVal[16] <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(IDX_WAKE_STAT, 8'h00, "wakeFall");
        apb(1'b0, 8'h23, 8'h00);
        chk("errRd", 32'h1, {31'h0, errV});
        chk("errData", 32'h0, rdV);
        $display("wake and error test done");
        finalReport();
    end
endmodule

//--- tb/ugp_gpio_sva.sv
// assertion checker for the port pin block, bound to its top
module ugp_gpio_sva
    import ugp_pkg::*;
#(
    parameter int HIGH_W = HIGH_W_FULL
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [LOW_W-1:0] lowPortOut,
    input wire logic [LOW_W-1:0] lowPortOe_b,
    input wire logic [LOW_W-1:0] lowPortPullEn,
    input wire logic [LOW_W*SINK_W-1:0] lowPortSink,
    input wire logic [HIGH_W_FULL-1:0] highPortOut,
    input wire logic [HIGH_W_FULL-1:0] highPortOe_b,
    input wire logic [HIGH_W_FULL-1:0] highPortPullEn,
    input wire logic [HIGH_W_FULL*SINK_W-1:0] highPortSink,
    input wire logic wakePinOut,
    input wire logic wakePinOe_b,
    input wire logic irq
);
    localparam logic [7:0] ABSENT = 8'hff << HIGH_W;
    logic wrDone;
    logic [3:0] wrHist_q;
    logic recentWr;
    assign wrDone = pready && pwrite;
    assign recentWr = wrDone || (wrHist_q != 4'h0);
    // pull, sink and drive outputs, and a falling irq, may only move within a few cycles of a completed write
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrHist_q <= 4'h0;
        end else begin
            wrHist_q <= {wrHist_q[2:0], wrDone};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence setupSeq;
        psel && !penable;
    endsequence
    sequence waitSeq;
        psel && penable && !pready ##1 pready;
    endsequence
    AST_ONE_WAIT: assert property (setupSeq |=> waitSeq)
        else $error("answer not after one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_ANSWER: assert property (
        pslverr |-> pready && prdata == '0)
        else $error("error response malformed");
    AST_UPPER_ZERO: assert property (
        pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_OPEN_DRAIN: assert property (
        lowPortOut == '0 && highPortOut == '0 && !wakePinOut)
        else $error("pin data driven high");
    AST_REDUCED: assert property (
        ((~highPortOe_b | highPortPullEn) & ABSENT) == 8'h0)
        else $error("absent high port bit active");
    AST_PULL_BY_WRITE: assert property (
        $changed({lowPortPullEn, highPortPullEn}) |-> recentWr)
        else $error("pull-up moved without write");
    AST_SINK_BY_WRITE: assert property (
        $changed({lowPortSink, highPortSink}) |-> recentWr)
        else $error("sink level moved without write");
    AST_OE_BY_WRITE: assert property (
        $changed({lowPortOe_b, highPortOe_b, wakePinOe_b}) |-> recentWr)
        else $error("pin drive moved without write");
    AST_IRQ_FALL: assert property ($fell(irq) |-> recentWr)
        else $error("irq dropped without write");
endmodule

bind ugp_gpio_top ugp_gpio_sva #(.HIGH_W(HIGH_W)) ugp_gpio_sva_inst (.*);

//--- tb/ugp_pin_load.sv
// external pin loads: switches, pull-ups and floating open-drain pins
module ugp_pin_load
#(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic [W-1:0] pinOe_b,
    input wire logic [W-1:0] pullEn,
    input wire logic [W-1:0] swEn,
    input wire logic [W-1:0] swVal,
    output logic [W-1:0] pinLevel
);
    logic [W-1:0] last_q;
    always_ff @(posedge core_clk) begin
        last_q <= pinLevel;
    end
    // a pin pulled low wins over any switch
    // with no switch and no pull-up the pin wanders, never trusted
    assign pinLevel = pinOe_b & ((swEn & swVal) | (~swEn & (pullEn | ~last_q)));
endmodule
